// File: logic/stsr_byte_gen.sv
// Byte generator for one sector of threshold or attribute data
`timescale 1ns/1ns
module stsr_byte_gen (
    // Selection
    input  wire logic        thresh_sel,
    input  wire logic [8:0]  byte_idx,
    // Counter snapshot
    input  wire logic [31:0] pwr_cycles,
    // Generated byte
    output logic [7:0]       byte_val
);
    // =====================================================================
    // Entry position decode
    wire        in_entries = (byte_idx >= stsr_pkg::ENTRY_FIRST) && (byte_idx < stsr_pkg::ENTRY_END);
    wire [8:0]  rel        = byte_idx - stsr_pkg::ENTRY_FIRST;
    wire [4:0]  entry_no   = 5'(rel / 9'(stsr_pkg::ENTRY_BYTES));
    wire [3:0]  entry_off  = 4'(rel % 9'(stsr_pkg::ENTRY_BYTES));
    wire        entry_used = entry_no < 5'(stsr_pkg::ATTR_COUNT);
    wire [7:0]  attr_id    = entry_used ? stsr_pkg::ATTR_IDS[entry_no[3:0]] : 8'h00;
    wire [31:0] raw        = (attr_id == stsr_pkg::PWR_CYCLE_ID) ? pwr_cycles : 32'h0;

    // Threshold entry: id then zero threshold, rest reserved
    wire [7:0] thr_b = (entry_off == 4'h0) ? attr_id : stsr_pkg::THRESH_VALUE;

    // Attribute entry: id, zero flags, value, worst, raw LSB first
    logic [7:0] att_b;
    always_comb begin
        unique case (entry_off)
            4'h0:    att_b = attr_id;
            4'h3:    att_b = stsr_pkg::CUR_VALUE;
            4'h4:    att_b = stsr_pkg::WORST_VALUE;
            4'h5:    att_b = raw[7:0];
            4'h6:    att_b = raw[15:8];
            4'h7:    att_b = raw[23:16];
            4'h8:    att_b = raw[31:24];
            default: att_b = 8'h00;
        endcase
    end

    // Sector byte select; tail bytes zero, checksum added by caller
    wire [7:0] ent_b = !entry_used ? 8'h00 : (thresh_sel ? thr_b : att_b);
    assign byte_val = (byte_idx == 9'h000) ? stsr_pkg::VERSION_WORD[7:0] :
                      (byte_idx == 9'h001) ? stsr_pkg::VERSION_WORD[15:8] :
                      in_entries           ? ent_b : 8'h00;
endmodule

// File: logic/stsr_pkg.sv
// Package with constants for the health-monitoring sector responder
package stsr_pkg;
    // =====================================================================
    // Task-file command decode values
    localparam logic [7:0] CMD_HEALTH    = 8'hb0;
    localparam logic [7:0] CYL_HI_KEY    = 8'hc2;
    localparam logic [7:0] CYL_LO_KEY    = 8'h4f;
    localparam logic [7:0] FEAT_THRESH   = 8'hd1;
    localparam logic [7:0] FEAT_DATA     = 8'hd0;
    // =====================================================================
    // Sector layout
    localparam int         SECTOR_BYTES  = 512;
    localparam logic [8:0] LAST_BYTE     = 9'h1ff;
    localparam logic [8:0] ENTRY_FIRST   = 9'h002;
    localparam logic [8:0] ENTRY_END     = 9'h16a;
    localparam logic [3:0] ENTRY_BYTES   = 4'hc;
    localparam logic [15:0] VERSION_WORD = 16'h0100;
    localparam logic [7:0] CUR_VALUE     = 8'h64;
    localparam logic [7:0] WORST_VALUE   = 8'h64;
    localparam logic [7:0] THRESH_VALUE  = 8'h00;
    localparam int         ATTR_COUNT    = 12;
    localparam logic [7:0] PWR_CYCLE_ID  = 8'h0c;
    // Attribute identifiers in entry order
    localparam logic [7:0] ATTR_IDS [ATTR_COUNT] = '{8'h01, 8'h02, 8'h05, 8'h07, 8'h08, 8'h0c,
                                                     8'hc3, 8'hc4, 8'hc5, 8'hc6, 8'hc7, 8'hc8};
    // =====================================================================
    // Responder states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SEND = 2'b01,
        ST_SUM  = 2'b10
    } stsr_state_e;
endpackage

// File: logic/stsr_responder.sv
// Top of the health-monitoring sector responder
// =========================================================================
// What this block does
// - Decode B0h, C2h/4Fh cylinder, feature D1h or D0h
// - Send exactly one sector per request
// - Version 0100h, 30 entries, zero tail, checksum
// - Threshold entry: id, zero threshold, reserved
// - Attribute entry: id, zero flags, value 64h
// - Worst value byte fixed at 64h
// - Raw value LSB first, power cycles only
// - Twelve attributes, each in own entry
`timescale 1ns/1ns
module stsr_responder #(
    parameter int CNT_W = 32
) (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    // Task-file command strobe and registers
    input  wire logic        cmd_valid,
    input  wire logic [7:0]  cmd_code,
    input  wire logic [7:0]  cyl_hi,
    input  wire logic [7:0]  cyl_lo,
    input  wire logic [7:0]  features,
    // Live power-cycle count
    input  wire logic [CNT_W-1:0] pwr_cycles,
    // Status
    output logic             busy,
    output logic             done,
    output logic             cmd_reject,
    // Data stream to host
    output logic             data_valid,
    input  wire logic        data_ready,
    output logic [7:0]       data_byte,
    output logic             data_last
);
    // =====================================================================
    // Parameter check
    if (CNT_W < 1 || CNT_W > 32) begin : g_bad_width
        $error("pwr_cycles width must be 1 to 32");
    end

    // =====================================================================
    // Command decode
    wire is_health = cmd_valid && (cmd_code == stsr_pkg::CMD_HEALTH)
                     && (cyl_hi == stsr_pkg::CYL_HI_KEY) && (cyl_lo == stsr_pkg::CYL_LO_KEY);
    wire go_thr    = is_health && (features == stsr_pkg::FEAT_THRESH);
    wire go_dat    = is_health && (features == stsr_pkg::FEAT_DATA);

    stsr_pkg::stsr_state_e state_q, state_d;
    logic [8:0]  idx_q;
    logic        sel_q;
    logic [7:0]  sum_q;
    logic [7:0]  byte_q;
    logic        last_q;
    logic        done_q;
    logic        rej_q;
    logic [7:0]  gen_b;
    logic [31:0] pc_q;

    // =====================================================================
    // Byte generator
    stsr_byte_gen u_gen (
        .thresh_sel (sel_q),
        .byte_idx   (idx_q),
        .pwr_cycles (pc_q),
        .byte_val   (gen_b)
    );

    wire idle   = (state_q == stsr_pkg::ST_IDLE);
    wire take   = data_valid && data_ready;
    wire at_end = (idx_q == stsr_pkg::LAST_BYTE);
    // Checksum byte is two's complement of the running sum
    wire [7:0] csum = 8'(8'h00 - sum_q);

    // Next state
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            stsr_pkg::ST_IDLE: if (go_thr || go_dat) state_d = stsr_pkg::ST_SEND;
            stsr_pkg::ST_SEND: if (take && idx_q == 9'(stsr_pkg::LAST_BYTE - 9'h001)) state_d = stsr_pkg::ST_SUM;
            stsr_pkg::ST_SUM:  if (take) state_d = stsr_pkg::ST_IDLE;
            default:           state_d = stsr_pkg::ST_IDLE;
        endcase
    end

    // State and index
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= stsr_pkg::ST_IDLE;
            idx_q   <= 9'h000;
            sel_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            if (idle) begin
                idx_q <= 9'h000;
                sel_q <= go_thr;
            end else if (take && !at_end) begin
                idx_q <= idx_q + 9'h001;
            end
        end
    end

    // Count snapshot at command start, so raw bytes cannot tear
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pc_q <= 32'h00000000;
        end else if (idle) begin
            pc_q <= 32'(pwr_cycles);
        end
    end

    // Running sum over bytes 0..510
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sum_q <= 8'h00;
        end else if (idle) begin
            sum_q <= 8'h00;
        end else if (take && !at_end) begin
            sum_q <= sum_q + data_byte;
        end
    end

    // Registered data byte and last flag
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            byte_q <= 8'h00;
            last_q <= 1'b0;
        end else begin
            byte_q <= (state_q == stsr_pkg::ST_SUM) ? csum : gen_b;
            last_q <= (state_q == stsr_pkg::ST_SUM);
        end
    end

    // Completion and reject pulses
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            done_q <= 1'b0;
            rej_q  <= 1'b0;
        end else begin
            done_q <= (state_q == stsr_pkg::ST_SUM) && take;
            rej_q  <= cmd_valid && !idle;
        end
    end

    // Valid set on the same edge that registers the byte at each new index
    logic vld_q;
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            vld_q <= 1'b0;
        end else begin
            vld_q <= !idle && !take && (state_d != stsr_pkg::ST_IDLE);
        end
    end

    // =====================================================================
    // Outputs
    assign data_valid = vld_q;
    assign data_byte  = byte_q;
    assign data_last  = last_q;
    assign busy       = !idle;
    assign done       = done_q;
    assign cmd_reject = rej_q;

    // =====================================================================
    // Checks
    logic [9:0] cnt_q;
    logic [7:0] chk_q;
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q <= 10'h000;
            chk_q <= 8'h00;
        end else if (idle) begin
            cnt_q <= 10'h000;
            chk_q <= 8'h00;
        end else if (take) begin
            cnt_q <= cnt_q + 10'h001;
            chk_q <= chk_q + data_byte;
        end
    end

    sequence s_thr_cmd;
        idle && go_thr;
    endsequence

    start_thr_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        s_thr_cmd |=> busy && sel_q)
        else $error("threshold command not started");
    no_start_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        idle && !go_thr && !go_dat |=> idle)
        else $error("busy without a valid command");
    one_sector_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        take && data_last |-> cnt_q == 10'h1ff)
        else $error("sector not 512 bytes");
    last_done_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        take && data_last |=> done ##1 !busy)
        else $error("no completion after last byte");
    version_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        take && cnt_q == 10'h001 |-> data_byte == 8'h01)
        else $error("version high byte wrong");
    tail_zero_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        take && sel_q && cnt_q > 10'h169 && cnt_q < 10'h1ff |-> data_byte == 8'h00)
        else $error("reserved tail not zero");
    thr_zero_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        take && sel_q && cnt_q == 10'h003 |-> data_byte == 8'h00)
        else $error("threshold not zero");
    att_val_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        take && !sel_q && cnt_q == 10'h005 |-> data_byte == 8'h64)
        else $error("attribute value not 64h");
    checksum_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        take && data_last |-> 8'(chk_q + data_byte) == 8'h00)
        else $error("sector sum not zero");

    sequence s_stalled;
        data_valid && !data_ready;
    endsequence

    stall_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        s_stalled |=> data_valid && $stable(data_byte) && $stable(data_last))
        else $error("byte changed while host stalled");
    byte_gap_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        take |=> !data_valid)
        else $error("no idle cycle after a taken byte");
    done_pulse_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        done |=> !done)
        else $error("completion longer than one cycle");
    reject_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        cmd_valid && busy |=> cmd_reject)
        else $error("command while busy not flagged");
    worst_val_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        take && !sel_q && cnt_q == 10'h006 |-> data_byte == 8'h64)
        else $error("worst value not 64h");
    raw_zero_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        take && !sel_q && cnt_q == 10'h007 |-> data_byte == 8'h00)
        else $error("raw value of idle attribute not zero");
    last_id_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        take && cnt_q == 10'h086 |-> data_byte == 8'hc8)
        else $error("twelfth attribute id wrong");
    spare_zero_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        take && cnt_q == 10'h092 |-> data_byte == 8'h00)
        else $error("unused entry not zero");
endmodule

// File: verif/stsr_host_model.sv
// Host-side sink model for the sector byte stream
`timescale 1ns/1ns
module stsr_host_model (
    // Clock
    input  wire logic sys_clk,
    // Stall request from the bench
    input  wire logic stall_en,
    // Ready toward the device
    output logic      data_ready
);
    // Ready steady, or dropped at random when stalling
    logic rdy_q = 1'b0;
    assign data_ready = rdy_q;
    always @(posedge sys_clk) begin
        rdy_q <= stall_en ? ($urandom_range(3) != 0) : 1'b1;
    end
endmodule

// File: verif/stsr_responder_test.sv
// Self-checking bench for the health-monitoring sector responder
`timescale 1ns/1ns
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_fail++; \
    $display("CHECK FAILED %0t %h %h", $time, (a), (b)); end end
module stsr_responder_test;
    // ==========
    // Signals
    logic        sys_clk    = 1'b0;
    logic        sys_rst    = 1'b1;
    logic        cmd_valid  = 1'b0;
    logic [7:0]  cmd_code   = 8'h00;
    logic [7:0]  cyl_hi     = 8'h00;
    logic [7:0]  cyl_lo     = 8'h00;
    logic [7:0]  features   = 8'h00;
    logic [31:0] pwr_cycles = 32'h0;
    logic        stall_en   = 1'b0;
    logic        busy, done, cmd_reject, data_valid, data_ready, data_last;
    logic [7:0]  data_byte;
    logic [8:0]  exp_q[$];
    logic [8:0]  note;
    int          n_fail = 0, checks_done = 0, rej_cnt = 0, rej_exp = 0;
    // ==========
    // Instances
    stsr_responder #(.CNT_W(32)) uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cyl_hi(cyl_hi), .cyl_lo(cyl_lo), .features(features),
        .pwr_cycles(pwr_cycles), .busy(busy), .done(done), .cmd_reject(cmd_reject),
        .data_valid(data_valid), .data_ready(data_ready), .data_byte(data_byte), .data_last(data_last));
    stsr_host_model host (.sys_clk(sys_clk), .stall_en(stall_en), .data_ready(data_ready));
    // 25 MHz clock
    always #20 sys_clk = ~sys_clk;
    // ==========
    // Expected sector contents
    function automatic logic [7:0] exp_byte(input logic th, input int i, input logic [31:0] pc);
        int k;
        int o;
        logic [7:0] id;
        k = (i - 2) / 12;
        o = (i - 2) % 12;
        id = (i >= 2 && k < 12) ? stsr_pkg::ATTR_IDS[k] : 8'h00;
        if (i < 2) return (i == 1) ? 8'h01 : 8'h00;
        if (i >= 362 || k >= 12) return 8'h00;
        if (o == 0) return id;
        if (th) return 8'h00;
        if (o == 3 || o == 4) return 8'h64;
        if (o >= 5 && o <= 8 && id == 8'h0c) return pc[8*(o-5) +: 8];
        return 8'h00;
    endfunction
    task automatic push_sector(input logic th, input logic [31:0] pc);
        logic [7:0] b;
        logic [7:0] sum;
        sum = 8'h00;
        for (int i = 0; i < 511; i++) begin
            b = exp_byte(th, i, pc);
            sum = sum + b;
            exp_q.push_back({1'b0, b});
        end
        exp_q.push_back({1'b1, 8'h00 - sum});
    endtask
    // ==========
    // Drivers
    task automatic send_cmd(input logic [7:0] c, input logic [7:0] h, input logic [7:0] l, input logic [7:0] f);
        @(posedge sys_clk);
        cmd_valid <= 1'b1;
        {cmd_code, cyl_hi, cyl_lo, features} <= {c, h, l, f};
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
        {cmd_code, cyl_hi, cyl_lo, features} <= ~{c, h, l, f};
    endtask
    task automatic wait_done();
        int n;
        n = 0;
        while (done !== 1'b1) begin
            @(posedge sys_clk);
            #1;
            n++;
            if (n > 4000) begin
                n_fail++;
                give_verdict();
            end
        end
    endtask
    task automatic run_sector(input logic [7:0] feat, input logic th, input logic stall, input logic dup);
        logic [31:0] pc;
        pc = $urandom();
        pwr_cycles <= pc;
        stall_en <= stall;
        push_sector(th, pc);
        send_cmd(8'hb0, 8'hc2, 8'h4f, feat);
        pwr_cycles <= ~pc;
        #1;
        `CHK(busy, 1'b1)
        if (dup) begin
            rej_exp++;
            send_cmd(8'hb0, 8'hc2, 8'h4f, feat);
        end
        wait_done();
        `CHK(exp_q.size(), 0)
        `CHK(busy, 1'b0)
    endtask
    task automatic give_verdict();
        if (n_fail == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Byte monitor: oldest note against each taken byte
    always @(posedge sys_clk) begin
        if (data_valid === 1'b1 && data_ready === 1'b1) begin
            note = (exp_q.size() > 0) ? exp_q.pop_front() : 9'h1ff;
            `CHK(data_byte, note[7:0])
            `CHK(data_last, note[8])
        end
        if (cmd_reject === 1'b1) rej_cnt++;
    end
    // ==========
    // Main sequence
    initial begin
        logic [31:0] f;
        void'($urandom(32'h5fa6));
        repeat (6) @(posedge sys_clk);
        sys_rst <= 1'b0;
        run_sector(8'hd1, 1'b1, 1'b0, 1'b0);
        run_sector(8'hd1, 1'b1, 1'b1, 1'b1);
        run_sector(8'hd0, 1'b0, 1'b1, 1'b0);
        run_sector(8'hd0, 1'b0, 1'b0, 1'b0);
        for (int m = 0; m < 4; m++) begin
            f = 32'hb0c24fd1 ^ (32'h20 << (8 * m));
            send_cmd(f[31:24], f[23:16], f[15:8], f[7:0]);
            repeat (3) @(posedge sys_clk);
            #1;
            `CHK({busy, data_valid}, 2'b00)
        end
        `CHK(rej_cnt, rej_exp)
        give_verdict();
    end
endmodule
